// >>> core/sra_pkg.sv
// Shared constants and carrier types of the serial receive aligner
package sra_pkg;
    // Word and half-word widths
    localparam int WORD_W = 10;
    localparam int HALF_W = 5;
    // Comma prefix, first received bit in the msb of the constant
    localparam logic [6:0] COMMA_PAT = 7'h1f;
    // Pattern test polynomial x^7 + x^6 + 1, seed
    localparam logic [6:0] PRBS_SEED = 7'h7f;
    // Longest clock stall during realignment, in bit times
    localparam int STRETCH_MAX_BITS = 20;
    // Latency bounds in bit times
    localparam int LAT_TBI_MIN = 18;
    localparam int LAT_TBI_MAX = 24;
    localparam int LAT_DDR_MIN = 17;
    localparam int LAT_DDR_MAX = 23;
    // Serial bit period in ns at the block clock rate (one bit per clock)
    localparam int CLK_PERIOD_NS = 50;
    localparam int BIT_NS = 50;
    localparam int BIT_CYCLES = (BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Reset values
    localparam logic [3:0] PHASE_RST = 4'h0;
    localparam logic [9:0] WORD_RST = 10'h000;

    // Static configuration pins, grouped
    typedef struct packed {
        logic bus_width_select;
        logic rx_clock_rate_select;
        logic comma_align_enable;
        logic serial_loopback_enable;
        logic pattern_test_enable;
        logic factory_test_enable;
    } sra_cfg_t;

    // Receive bus presented to the controller
    typedef struct packed {
        logic [9:0] rx_word_lines;
        logic rx_byte_clock_a;
        logic rx_byte_clock_b;
        logic sync_pass;
    } sra_rxbus_t;
endpackage : sra_pkg

// >>> core/sra_prbs.sv
// Seven-bit pseudo-random generator and self-synchronising checker
`timescale 1ns/1ps
module sra_prbs
    import sra_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic run_in,
    input wire logic rx_bit_in,
    output logic tx_bit_out,
    output logic err_out
);
    import sra_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Next state of a 2^7-1 register
    function automatic logic [6:0] prbs_step(input logic [6:0] s);
        prbs_step = {s[5:0], s[6] ^ s[5]};
    endfunction : prbs_step

    logic [6:0] gen_ff; // Generator state
    logic [6:0] chk_ff; // Checker history of received bits
    logic err_ff; // Mismatch seen this bit
    logic [6:0] nxt_gen;
    logic [6:0] nxt_chk;
    logic nxt_err;

    // Generator runs freely; checker predicts from its own past bits
    always_comb
    begin
        nxt_gen = gen_ff;
        nxt_chk = chk_ff;
        nxt_err = 1'b0;
        if (run_in)
        begin
            nxt_gen = prbs_step(gen_ff);
            nxt_chk = {chk_ff[5:0], rx_bit_in};
            nxt_err = rx_bit_in ^ (chk_ff[6] ^ chk_ff[5]);
        end
    end

    // Registers only
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            gen_ff <= PRBS_SEED;
            chk_ff <= PRBS_SEED;
            err_ff <= 1'b0;
        end
        else
        begin
            gen_ff <= nxt_gen;
            chk_ff <= nxt_chk;
            err_ff <= nxt_err;
        end
    end

    assign tx_bit_out = gen_ff[6];
    assign err_out = err_ff;
endmodule : sra_prbs

// >>> core/sra_comma_find.sv
// Sliding comma detector over the last ten received bits
`timescale 1ns/1ps
module sra_comma_find
    import sra_pkg::*;
(
    input wire logic [9:0] window_in,
    output logic hit_out
);
    import sra_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Oldest bit at window_in[0]; comma's first bit must sit there
    always_comb
    begin
        hit_out = ({window_in[0], window_in[1], window_in[2], window_in[3],
                    window_in[4], window_in[5], window_in[6]} == COMMA_PAT);
    end
endmodule : sra_comma_find

// >>> core/sra_rx_align.sv
// Receive deserialiser, comma aligner, byte clocks, sync/pass and test pins
//
// Behaviour
// - Width select low ten-bit, high five-bit
// - Rate select picks half or full rate
// - Half rate: two clocks, opposite phase
// - Half rate words alternate, comma on b
// - Full rate: clock a only, b low
// - Five-bit: both edges of a, b low
// - Lock straight from data, no reference phase
// - Align enable compares bits with comma prefix
// - Shift boundary only on straddling comma
// - Clocks held during realignment, bounded stretch
// - Align enable low: no alignment
// - Sync pulse with comma word
// - Ten-bit latency within bounds, bit 0 first
// - Five-bit latency within bounds
// - Loopback feeds transmit, outputs high impedance
// - Enable low idles all logic but the test pins; the code still counts stall_ff down while enable is low
// - Pattern test drives generated sequence out
// - Pattern errors drive sync/pass low
// - Pattern test ignores rate select
// - Align enable low live, high latched
// - Factory test defaults off, high test
// - Tap reset low holds TAP reset
`timescale 1ns/1ps
module sra_rx_align
    import sra_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire sra_pkg::sra_cfg_t cfg_in,
    input wire logic tap_reset_n_in,
    input wire logic serial_rx_in,
    input wire logic serial_tx_data_in,
    output sra_pkg::sra_rxbus_t rx_bus_out,
    output logic serial_tx_out,
    output logic serial_tx_oe_out,
    output logic tap_in_reset_out,
    output logic test_mode_out
);
    import sra_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    logic ddr_mode; // Five-bit bus
    logic full_rate; // Full-rate byte clock
    logic ptest; // Pattern test running
    always_comb
    begin
        ptest = cfg_in.pattern_test_enable & enable_in;
        ddr_mode = cfg_in.bus_width_select;
        // Five-bit and pattern test always full rate
        full_rate = ddr_mode | ptest | cfg_in.rx_clock_rate_select;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit side test path and loopback
    logic prbs_tx; // Generated sequence bit
    logic prbs_err; // Checker mismatch
    logic tx_bit; // Bit being serialised
    logic rx_bit; // Bit entering receiver
    logic tx_ff;
    logic tx_oe_ff;
    logic nxt_tx;
    logic nxt_tx_oe;

    sra_prbs u_prbs (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .run_in(ptest),
        .rx_bit_in(rx_bit),
        .tx_bit_out(prbs_tx),
        .err_out(prbs_err)
    );

    // Loopback replaces the line with our own transmit bit
    always_comb
    begin
        tx_bit = ptest ? prbs_tx : serial_tx_data_in;
        rx_bit = cfg_in.serial_loopback_enable ? tx_ff : serial_rx_in;
        nxt_tx = enable_in ? tx_bit : 1'b0;
        nxt_tx_oe = enable_in & ~cfg_in.serial_loopback_enable;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift register and boundary tracking
    logic [9:0] shift_ff; // Newest bit at [9], oldest at [0]
    logic [3:0] phase_ff; // Bit count within the word
    logic [3:0] stall_ff; // Remaining bits of clock hold
    logic [9:0] word_ff; // Latched aligned word
    logic word_comma_ff; // Latched word held a comma
    logic word_tgl_ff; // Toggles per finished word
    logic [9:0] nxt_shift;
    logic [3:0] nxt_phase;
    logic [3:0] nxt_stall;
    logic [9:0] nxt_word;
    logic nxt_word_comma;
    logic nxt_word_tgl;
    logic comma_hit;
    logic [9:0] window;

    always_comb
    begin
        window = {rx_bit, shift_ff[9:1]};
    end

    sra_comma_find u_find (
        .window_in(window),
        .hit_out(comma_hit)
    );

    // A comma found as the word completes at phase 9 is on boundary; elsewhere, re-base.
    // Recovery locks to data alone, so there is no reference phase.
    always_comb
    begin
        nxt_shift = enable_in ? window : shift_ff;
        nxt_phase = phase_ff;
        nxt_stall = (stall_ff != 4'h0) ? stall_ff - 4'h1 : stall_ff;
        nxt_word = word_ff;
        nxt_word_comma = word_comma_ff;
        nxt_word_tgl = word_tgl_ff;
        if (enable_in)
        begin
            if (cfg_in.comma_align_enable && comma_hit && phase_ff != 4'h9)
            begin
                // Truncate current word, restart boundary at this comma
                nxt_word = window;
                nxt_word_comma = 1'b1;
                nxt_word_tgl = ~word_tgl_ff;
                nxt_phase = PHASE_RST;
                nxt_stall = 4'(STRETCH_MAX_BITS / 2);
            end
            else if (phase_ff == 4'h9)
            begin
                // Normal word end; without align enable no comma tracking
                nxt_word = window;
                nxt_word_comma = cfg_in.comma_align_enable & comma_hit;
                nxt_word_tgl = ~word_tgl_ff;
                nxt_phase = PHASE_RST;
            end
            else
            begin
                nxt_phase = phase_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            shift_ff <= WORD_RST;
            phase_ff <= PHASE_RST;
            stall_ff <= 4'h0;
            word_ff <= WORD_RST;
            word_comma_ff <= 1'b0;
            word_tgl_ff <= 1'b0;
            tx_ff <= 1'b0;
            tx_oe_ff <= 1'b0;
        end
        else
        begin
            shift_ff <= nxt_shift;
            phase_ff <= nxt_phase;
            stall_ff <= nxt_stall;
            word_ff <= nxt_word;
            word_comma_ff <= nxt_word_comma;
            word_tgl_ff <= nxt_word_tgl;
            tx_ff <= nxt_tx;
            tx_oe_ff <= nxt_tx_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output bus, byte clocks and sync/pass
    logic seen_tgl_ff; // Last word toggle acted on
    logic half_sel_ff; // Half-rate: next word goes to clock b
    logic clk_a_ff;
    logic clk_b_ff;
    logic [9:0] lines_ff;
    logic sync_ff;
    logic fail_ff; // Latched pattern failure
    logic nxt_seen_tgl;
    logic nxt_half_sel;
    logic nxt_clk_a;
    logic nxt_clk_b;
    logic [9:0] nxt_lines;
    logic nxt_sync;
    logic nxt_fail;
    logic new_word;
    logic mid_word;

    always_comb
    begin
        new_word = (word_tgl_ff != seen_tgl_ff);
        mid_word = (phase_ff == 4'h4);
        nxt_seen_tgl = word_tgl_ff;
        nxt_half_sel = half_sel_ff;
        nxt_clk_a = clk_a_ff;
        nxt_clk_b = full_rate ? 1'b0 : clk_b_ff;
        nxt_lines = lines_ff;
        nxt_sync = sync_ff;
        nxt_fail = fail_ff | (cfg_in.comma_align_enable & prbs_err);
        if (!ptest || !cfg_in.comma_align_enable)
        begin
            nxt_fail = 1'b0;
        end
        if (!enable_in)
        begin
            // Idle: everything parked low
            nxt_clk_a = 1'b0;
            nxt_clk_b = 1'b0;
            nxt_lines = WORD_RST;
            nxt_sync = 1'b0;
        end
        else if (ptest)
        begin
            // Checker result replaces sync; ten-bit bus assumed
            nxt_sync = ~(prbs_err | nxt_fail);
            if (new_word)
            begin
                nxt_lines = word_ff;
                nxt_clk_a = 1'b1;
                nxt_clk_b = 1'b0;
            end
            else if (mid_word)
            begin
                nxt_clk_a = 1'b0;
            end
        end
        else if (stall_ff != 4'h0 && !new_word)
        begin
            // Hold clocks where they are while boundary moves
            nxt_clk_a = clk_a_ff;
        end
        else if (new_word)
        begin
            nxt_sync = word_comma_ff;
            if (ddr_mode)
            begin
                nxt_lines = {5'h00, word_ff[4:0]};
                nxt_clk_a = 1'b1;
                nxt_clk_b = 1'b0;
            end
            else if (full_rate)
            begin
                nxt_lines = word_ff;
                nxt_clk_a = 1'b1;
                nxt_clk_b = 1'b0;
            end
            else
            begin
                // Comma word always lands on clock b
                nxt_lines = word_ff;
                if (word_comma_ff || half_sel_ff)
                begin
                    nxt_clk_b = 1'b1;
                    nxt_clk_a = 1'b0;
                    nxt_half_sel = 1'b0;
                end
                else
                begin
                    nxt_clk_a = 1'b1;
                    nxt_clk_b = 1'b0;
                    nxt_half_sel = 1'b1;
                end
            end
        end
        else if (mid_word && ddr_mode)
        begin
            // Second half-word on the falling edge; sync spans the period
            nxt_lines = {5'h00, word_ff[9:5]};
            nxt_clk_a = 1'b0;
        end
        else if (mid_word && full_rate)
        begin
            nxt_clk_a = 1'b0;
        end
    end

    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            seen_tgl_ff <= 1'b0;
            half_sel_ff <= 1'b0;
            clk_a_ff <= 1'b0;
            clk_b_ff <= 1'b0;
            lines_ff <= WORD_RST;
            sync_ff <= 1'b0;
            fail_ff <= 1'b0;
        end
        else
        begin
            seen_tgl_ff <= nxt_seen_tgl;
            half_sel_ff <= nxt_half_sel;
            clk_a_ff <= nxt_clk_a;
            clk_b_ff <= nxt_clk_b;
            lines_ff <= nxt_lines;
            sync_ff <= nxt_sync;
            fail_ff <= nxt_fail;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test pins; factory pin is pulled low outside, so low means normal
    logic tap_rst_ff;
    logic test_ff;
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tap_rst_ff <= 1'b1;
            test_ff <= 1'b0;
        end
        else
        begin
            tap_rst_ff <= ~tap_reset_n_in;
            test_ff <= cfg_in.factory_test_enable;
        end
    end

    assign rx_bus_out.rx_word_lines = lines_ff;
    assign rx_bus_out.rx_byte_clock_a = clk_a_ff;
    assign rx_bus_out.rx_byte_clock_b = clk_b_ff;
    assign rx_bus_out.sync_pass = sync_ff;
    assign serial_tx_out = tx_ff;
    assign serial_tx_oe_out = tx_oe_ff;
    assign tap_in_reset_out = tap_rst_ff;
    assign test_mode_out = test_ff;
endmodule : sra_rx_align

// >>> tb/sra_rx_align_chk.sv
// Port checker for the receive aligner
`timescale 1ns/1ps
module sra_rx_align_chk
    import sra_pkg::*;
(
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic enable_in,
    input wire sra_pkg::sra_cfg_t cfg_in,
    input wire logic tap_reset_n_in,
    input wire sra_pkg::sra_rxbus_t rx_bus_out,
    input wire logic serial_tx_oe_out,
    input wire logic tap_in_reset_out,
    input wire logic test_mode_out
);
    import sra_pkg::*;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    ////////////////////////////////////////////////////////////////////
    // Mode decodes
    logic full_w;
    logic tbi_al_w;
    logic raw_w;
    assign full_w = !cfg_in.bus_width_select && cfg_in.rx_clock_rate_select
        && !cfg_in.pattern_test_enable;
    assign tbi_al_w = !cfg_in.bus_width_select && cfg_in.comma_align_enable
        && !cfg_in.pattern_test_enable;
    assign raw_w = full_w && !cfg_in.comma_align_enable;
    // Cycles clock a has kept one level; pattern test excluded
    logic [7:0] hold_ff;
    logic [7:0] nxt_hold;
    logic clk_a_ff;
    logic nxt_clk_a;
    always_comb
    begin
        nxt_clk_a = rx_bus_out.rx_byte_clock_a;
        nxt_hold = 8'h00;
        // At 8'hff the count returns to zero, as on a change of level
        if (enable_in && !cfg_in.pattern_test_enable && clk_a_ff == nxt_clk_a
            && hold_ff != 8'hff)
            nxt_hold = hold_ff + 8'h01;
    end
    always_ff @(posedge clock_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            hold_ff <= 8'h00;
            clk_a_ff <= 1'b0;
        end
        else
        begin
            hold_ff <= nxt_hold;
            clk_a_ff <= nxt_clk_a;
        end
    end
    ////////////////////////////////////////////////////////////////////
    full_b_low_a: assert property (full_w |=> !rx_bus_out.rx_byte_clock_b)
        else $error("clock b not low in full rate");
    loop_hiz_a: assert property (cfg_in.serial_loopback_enable |=> !serial_tx_oe_out)
        else $error("serial out driven in loopback");
    tap_hold_a: assert property (1'b1 |=> tap_in_reset_out == !$past(tap_reset_n_in))
        else $error("tap reset does not follow its pin");
    test_pin_a: assert property (1'b1 |=> test_mode_out == $past(cfg_in.factory_test_enable))
        else $error("test mode does not follow its pin");
    idle_low_a: assert property (!enable_in |=> rx_bus_out == '0 && !serial_tx_oe_out)
        else $error("outputs active while disabled");
    sync_comma_a: assert property (tbi_al_w && $stable(cfg_in) && rx_bus_out.sync_pass
        |-> rx_bus_out.rx_word_lines[6:0] == 7'h7c)
        else $error("sync without comma word");
    word_hold_a: assert property (raw_w && $rose(rx_bus_out.rx_byte_clock_a)
        |=> $stable(rx_bus_out.rx_word_lines) [*8])
        else $error("word changed inside its period");
    stretch_bound_a: assert property (hold_ff < 8'h1e)
        else $error("byte clock stalled too long");
    ddr_b_low_a: assert property (cfg_in.bus_width_select |=> !rx_bus_out.rx_byte_clock_b)
        else $error("clock b not low in five-bit mode");
    ddr_upper_a: assert property ($past(cfg_in.bus_width_select && !cfg_in.pattern_test_enable)
        && $fell(rx_bus_out.rx_byte_clock_a) |-> rx_bus_out.rx_word_lines[9:5] == 5'h00)
        else $error("upper lines active in five-bit mode");
    cover property (cfg_in.bus_width_select && rx_bus_out.sync_pass);
    cover property (tbi_al_w && rx_bus_out.sync_pass && rx_bus_out.rx_byte_clock_b);
    cover property (cfg_in.pattern_test_enable && !rx_bus_out.sync_pass);
    cover property (raw_w && $rose(rx_bus_out.rx_byte_clock_a));
endmodule : sra_rx_align_chk

// >>> tb/sra_ctrl_model.sv
// Protocol controller model capturing receive words
`timescale 1ns/1ps
module sra_ctrl_model
    import sra_pkg::*;
(
    input wire logic clock_in,
    input wire sra_pkg::sra_rxbus_t rx_bus_in,
    output logic [9:0] sync_word_out,
    output logic sync_on_b_out,
    output logic [9:0] next_word_out
);
    import sra_pkg::*;
    logic a_ff = 1'b0;
    logic b_ff = 1'b0;
    logic was_sync = 1'b0;
    // Capture on a rising edge of either byte clock
    always @(posedge clock_in)
    begin
        if ((rx_bus_in.rx_byte_clock_a && !a_ff) || (rx_bus_in.rx_byte_clock_b && !b_ff))
        begin
            if (was_sync)
                next_word_out <= rx_bus_in.rx_word_lines;
            if (rx_bus_in.sync_pass)
            begin
                sync_word_out <= rx_bus_in.rx_word_lines;
                sync_on_b_out <= rx_bus_in.rx_byte_clock_b && !b_ff;
            end
            was_sync <= rx_bus_in.sync_pass;
        end
        a_ff <= rx_bus_in.rx_byte_clock_a;
        b_ff <= rx_bus_in.rx_byte_clock_b;
    end
endmodule : sra_ctrl_model

// >>> tb/tb_serdes_rx_align_and_selftest.sv
// Testbench top for the receive aligner
`timescale 1ns/1ps
module tb_serdes_rx_align_and_selftest;
    import sra_pkg::*;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic enable_in = 1'b0;
    logic tap_reset_n_in = 1'b0;
    logic serial_rx_in = 1'b0;
    sra_cfg_t cfg = 6'h18; // Full rate, align on
    sra_rxbus_t rx_bus_out;
    logic serial_tx_oe_out;
    logic tap_in_reset_out;
    logic test_mode_out;
    logic [9:0] sync_word;
    logic [9:0] next_word;
    logic sync_on_b;
    int fails = 0;
    int checks_done = 0;
    always #25 clock_in = ~clock_in;
    ////////////////////////////////////////////////////////////////////
    sra_rx_align dut_u (.clock_in(clock_in), .reset_in(reset_in), .enable_in(enable_in),
        .cfg_in(cfg), .tap_reset_n_in(tap_reset_n_in), .serial_rx_in(serial_rx_in),
        .serial_tx_data_in(1'b0), .rx_bus_out(rx_bus_out), .serial_tx_out(),
        .serial_tx_oe_out(serial_tx_oe_out), .tap_in_reset_out(tap_in_reset_out),
        .test_mode_out(test_mode_out));
    sra_ctrl_model ctrl_u (.clock_in(clock_in), .rx_bus_in(rx_bus_out),
        .sync_word_out(sync_word), .sync_on_b_out(sync_on_b), .next_word_out(next_word));
    ////////////////////////////////////////////////////////////////////
    // Hold the serial line at one level for n bits
    task automatic line(input logic v, input int n);
        repeat (n) @(negedge clock_in) serial_rx_in = v;
    endtask : line
    // One word, bit 0 first
    task automatic send_word(input logic [9:0] w);
        for (int i = 0; i < 10; i++)
            @(negedge clock_in) serial_rx_in = w[i];
    endtask : send_word
    // Commas spaced two words apart so each lands on the same clock
    task automatic stream();
        repeat (3)
        begin
            send_word(10'h17c);
            send_word(10'h2aa);
        end
        line(1'b0, 40);
    endtask : stream
    task automatic check1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check1
    task automatic check10(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check10
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        line(1'b0, 10);
        check1("tap in reset", 1'b1, tap_in_reset_out);
        check1("sync in reset", 1'b0, rx_bus_out.sync_pass);
        reset_in = 1'b0;
        enable_in = 1'b1;
        tap_reset_n_in = 1'b1;
        line(1'b0, 20);
        check1("tap released", 1'b0, tap_in_reset_out);
        check1("tx driven", 1'b1, serial_tx_oe_out);
        stream();
        check10("full comma", 10'h17c, sync_word);
        check10("full data", 10'h2aa, next_word);
        check1("full on b", 1'b0, sync_on_b);
        cfg.rx_clock_rate_select = 1'b0;
        line(1'b0, 3); // Forces a boundary shift
        stream();
        check10("half comma", 10'h17c, sync_word);
        check10("half data", 10'h2aa, next_word);
        check1("half on b", 1'b1, sync_on_b);
        cfg.bus_width_select = 1'b1;
        stream();
        check10("ddr comma", 10'h01c, sync_word);
        check10("ddr data", 10'h00a, next_word);
        check1("ddr on b", 1'b0, sync_on_b);
        cfg = 6'h10; // Full rate, align off
        line(1'b0, 7);
        stream();
        cfg.comma_align_enable = 1'b1;
        cfg.serial_loopback_enable = 1'b1;
        line(1'b0, 3);
        check1("loop tx off", 1'b0, serial_tx_oe_out);
        cfg.serial_loopback_enable = 1'b0;
        cfg.factory_test_enable = 1'b1;
        line(1'b0, 3);
        check1("test mode", 1'b1, test_mode_out);
        cfg.factory_test_enable = 1'b0;
        cfg.pattern_test_enable = 1'b1;
        line(1'b1, 30);
        check1("latched fail", 1'b0, rx_bus_out.sync_pass);
        cfg.serial_loopback_enable = 1'b1;
        line(1'b0, 40);
        check1("latched hold", 1'b0, rx_bus_out.sync_pass);
        cfg.comma_align_enable = 1'b0;
        cfg.rx_clock_rate_select = 1'b0;
        line(1'b0, 40);
        check1("live pass", 1'b1, rx_bus_out.sync_pass);
        cfg.serial_loopback_enable = 1'b0;
        line(1'b1, 20);
        check1("live fail", 1'b0, rx_bus_out.sync_pass);
        cfg.pattern_test_enable = 1'b0;
        enable_in = 1'b0;
        tap_reset_n_in = 1'b0;
        line(1'b0, 3);
        check10("idle lines", 10'h000, rx_bus_out.rx_word_lines);
        check1("idle clock", 1'b0, rx_bus_out.rx_byte_clock_a);
        check1("tap held", 1'b1, tap_in_reset_out);
        finish_test();
    end
endmodule : tb_serdes_rx_align_and_selftest
////////////////////////////////////////////////////////////////////////
bind sra_rx_align sra_rx_align_chk chk_u (.clock_in(clock_in), .reset_in(reset_in),
    .enable_in(enable_in), .cfg_in(cfg_in), .tap_reset_n_in(tap_reset_n_in),
    .rx_bus_out(rx_bus_out), .serial_tx_oe_out(serial_tx_oe_out),
    .tap_in_reset_out(tap_in_reset_out), .test_mode_out(test_mode_out));
